// [rtl/memory_map_control.sv]
// The APB register port was decided locally.
`timescale 1ns/1ps
// Operation
// - zero-page base: writable anytime in special, once only in normal modes
// - direct addressing takes address bits 15..8 from the page base
// - page base placement identical for local and global mapping
// - mode pin rules during reset; captured into mode bit 7 after
// - forbidden mode write keeps the bit and locks it outside special
// - no mode change by write while secured
// - info row visible at 0x0_0400..0x0_047F only when enabled
// - normal single-chip: internal memory only, no external bus
// - special single-chip: active debug controls cpu execution
// - debug resources selected only in debug read/write cycles
// - active debug shows debug resources at 0xFF00..0xFFFF, hides sharers
// - active debug with page 0xFF also decodes them at 0xBF00..0xBFFF
// - four page bits select a 16 kbyte block in the 0x8000 window
// - page index reachable by normal and far call/return accesses
// - 0xC000..0xFFFF always unpaged fixed block
// - page index resets to 0xFE
// - cpu access to unimplemented area triggers reset; firmware and debug allowed
module memory_map_control #(
	parameter int ADDR_W     = 12,
	parameter int RAM_SIZE   = 2048,
	parameter int FLASH_SIZE = 32768
) (
	// clock and reset
	input  wire logic               CLOCK,
	input  wire logic               RESET,
	// apb slave
	input  wire logic               PSEL,
	input  wire logic               PENABLE,
	input  wire logic               PWRITE,
	input  wire logic [ADDR_W-1:0]  PADDR,
	input  wire logic [31:0]        PWDATA,
	output logic      [31:0]        PRDATA,
	output logic                    PREADY,
	output logic                    PSLVERR,
	// device state
	input  wire logic               MODE_PIN,
	input  wire logic               SECURED,
	input  wire logic               DEBUG_ACTIVE,
	// far call / return page access
	input  wire logic               PAGE_WR,
	input  wire logic [7:0]         PAGE_WDATA,
	output logic      [7:0]         PAGE_RDATA,
	// cpu / debug access mapping
	input  mmc_pkg::cpu_req_t       CPU_REQ,
	output logic      [17:0]        GLOBAL_ADDR,
	output mmc_pkg::map_sel_t       MAP_SEL,
	output logic                    ILLEGAL_RESET,
	// mode outputs
	output logic                    OP_MODE_SPECIAL,
	output logic                    DEBUG_CONTROL,
	output logic                    EXT_BUS_EN
);
	import mmc_pkg::*;

	// ****************************************
	// parameter checks
	// ****************************************
	if (ADDR_W < 11) begin : g_chk_addr
		$error("ADDR_W too small for register map");
	end
	if (RAM_SIZE < 1 || FLASH_SIZE < 1 ||
		19'(RAM_SIZE) + RAM_LO > GLOBAL_END - 19'(FLASH_SIZE)) begin : g_chk_mem
		$error("memory sizes do not fit the global map");
	end

	// ****************************************
	// declarations
	// ****************************************
	mmc_state_t  s_reg;
	mmc_state_t  s_next;
	logic        apb_setup;
	logic        apb_write;
	logic        idx_ok;
	logic [7:0]  idx;
	logic [31:0] rd_word;
	logic        mode_next;
	logic        lock_next;
	logic [17:0] tr_gaddr;
	map_sel_t    tr_sel;
	logic        dbg_cycle;

	// ****************************************
	// apb decode
	// ****************************************
	assign idx       = PADDR[9:2];
	assign idx_ok    = (PADDR[1:0] == 2'b00) && (PADDR[ADDR_W-1:10] == '0) &&
		(idx == IDX_PAGE || idx == IDX_DIRECT || idx == IDX_MODE ||
		idx == IDX_CTRL || idx == IDX_STATUS);
	assign apb_setup = PSEL && !PENABLE;
	assign apb_write = PSEL && PENABLE && PWRITE && idx_ok;
	// zero wait states: read data is prepared in the setup cycle
	assign PREADY    = 1'b1;
	assign PSLVERR   = PSEL && PENABLE && !idx_ok;
	assign PRDATA    = s_reg.prdata;

	always_comb begin
		rd_word = '0;
		unique case (idx)
			IDX_PAGE:   rd_word[7:0] = {PAGE_UPPER, s_reg.page};
			IDX_DIRECT: rd_word[7:0] = s_reg.direct;
			IDX_MODE:   rd_word[MODE_BIT] = s_reg.mode;
			IDX_CTRL:   rd_word[INFO_BIT] = s_reg.info_vis;
			IDX_STATUS: rd_word[3:0] = {s_reg.captured, SECURED,
				s_reg.direct_written, s_reg.mode_lock};
			default:    rd_word = '0;
		endcase
	end

	// ****************************************
	// helpers
	// ****************************************
	mode_guard u_mode_guard (
		.cur_mode  (s_reg.mode),
		.cur_lock  (s_reg.mode_lock),
		.secured   (SECURED),
		.wr_val    (PWDATA[MODE_BIT]),
		.next_mode (mode_next),
		.next_lock (lock_next)
	);

	addr_translate #(
		.RAM_SIZE   (RAM_SIZE),
		.FLASH_SIZE (FLASH_SIZE)
	) u_addr_translate (
		.req        (CPU_REQ),
		.page       (s_reg.page),
		.direct     (s_reg.direct),
		.info_vis   (s_reg.info_vis),
		.dbg_active (DEBUG_ACTIVE),
		.gaddr      (tr_gaddr),
		.sel        (tr_sel)
	);

	assign dbg_cycle = CPU_REQ.dbg_rd || CPU_REQ.dbg_wr;

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		s_next         = s_reg;
		s_next.illegal = 1'b0;
		// first edge after reset release takes the mode pin
		if (!s_reg.captured) begin
			s_next.mode     = MODE_PIN;
			s_next.captured = 1'b1;
		end
		if (apb_setup) begin
			s_next.prdata = idx_ok ? rd_word : '0;
		end
		if (apb_write) begin
			unique case (idx)
				IDX_PAGE: begin
					s_next.page = PWDATA[3:0];
				end
				IDX_DIRECT: begin
					// lock only falls at reset
					if (s_reg.mode == MODE_SPECIAL || !s_reg.direct_written) begin
						s_next.direct         = PWDATA[7:0];
						s_next.direct_written = 1'b1;
					end
				end
				IDX_MODE: begin
					if (s_reg.captured) begin
						s_next.mode      = mode_next;
						s_next.mode_lock = lock_next;
					end
				end
				IDX_CTRL: begin
					s_next.info_vis = PWDATA[INFO_BIT];
				end
				default: begin
					s_next.info_vis = s_reg.info_vis;
				end
			endcase
		end
		// instruction page writes win over a same-cycle bus write
		if (PAGE_WR) begin
			s_next.page = PAGE_WDATA[3:0];
		end
		s_next.gaddr = s_reg.gaddr;
		s_next.sel   = '0;
		if (CPU_REQ.valid) begin
			s_next.gaddr = tr_gaddr;
			s_next.sel   = tr_sel;
			// both modes are single-chip; firmware and debug cycles exempt
			s_next.illegal = tr_sel.unimpl && !CPU_REQ.firmware && !dbg_cycle;
		end
	end

	always_ff @(posedge CLOCK or posedge RESET) begin
		if (RESET) begin
			s_reg        <= '0;
			s_reg.page   <= PAGE_RESET;
			s_reg.direct <= DIRECT_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign PAGE_RDATA      = {PAGE_UPPER, s_reg.page};
	assign GLOBAL_ADDR     = s_reg.gaddr;
	assign MAP_SEL         = s_reg.sel;
	assign ILLEGAL_RESET   = s_reg.illegal;
	// pin governs until its level has been captured
	assign OP_MODE_SPECIAL = s_reg.captured ? (s_reg.mode == MODE_SPECIAL) :
		(MODE_PIN == MODE_SPECIAL);
	assign DEBUG_CONTROL   = OP_MODE_SPECIAL;
	// single-chip only: no external bus in any mode
	assign EXT_BUS_EN      = 1'b0;

	// ****************************************
	// assertions
	// ****************************************
	logic wr_direct;
	logic wr_mode;
	assign wr_direct = apb_write && idx == IDX_DIRECT;
	assign wr_mode   = apb_write && idx == IDX_MODE;

	property p_direct_once;
		@(posedge CLOCK) disable iff (RESET)
		wr_direct && s_reg.mode == MODE_NORMAL && s_reg.direct_written
			|=> $stable(s_reg.direct);
	endproperty
	a_direct_once: assert property (p_direct_once)
		else $error("page base changed by second normal-mode write");

	property p_direct_special;
		@(posedge CLOCK) disable iff (RESET)
		wr_direct && s_reg.mode == MODE_SPECIAL
			|=> s_reg.direct == $past(PWDATA[7:0]) && s_reg.direct_written;
	endproperty
	a_direct_special: assert property (p_direct_special)
		else $error("special-mode page base write not taken");

	property p_direct_map;
		@(posedge CLOCK) disable iff (RESET)
		CPU_REQ.valid && CPU_REQ.direct && !PAGE_WR
			|=> GLOBAL_ADDR[13:0] == {$past(s_reg.direct[5:0]), $past(CPU_REQ.addr[7:0])};
	endproperty
	a_direct_map: assert property (p_direct_map)
		else $error("direct access not placed on page base");

	property p_mode_capture;
		@(posedge CLOCK) disable iff (RESET)
		// the release edge itself still samples reset high: no capture there
		!RESET && !s_reg.captured |=> s_reg.captured && s_reg.mode == $past(MODE_PIN);
	endproperty
	a_mode_capture: assert property (p_mode_capture)
		else $error("mode pin not captured after reset");

	property p_mode_secured;
		@(posedge CLOCK) disable iff (RESET)
		wr_mode && SECURED |=> $stable(s_reg.mode);
	endproperty
	a_mode_secured: assert property (p_mode_secured)
		else $error("mode changed while secured");

	property p_mode_forbid;
		@(posedge CLOCK) disable iff (RESET)
		wr_mode && s_reg.captured && s_reg.mode == MODE_NORMAL &&
			PWDATA[MODE_BIT] == MODE_SPECIAL
			|=> s_reg.mode == MODE_NORMAL && s_reg.mode_lock ##1 s_reg.mode_lock;
	endproperty
	a_mode_forbid: assert property (p_mode_forbid)
		else $error("forbidden mode write not refused and locked");

	property p_info_hidden;
		@(posedge CLOCK) disable iff (RESET)
		MAP_SEL.info_row |-> $past(s_reg.info_vis) &&
			GLOBAL_ADDR >= INFO_LO[17:0] && GLOBAL_ADDR <= INFO_HI[17:0];
	endproperty
	a_info_hidden: assert property (p_info_hidden)
		else $error("info row selected while hidden or out of range");

	property p_debug_cycles;
		@(posedge CLOCK) disable iff (RESET)
		MAP_SEL.debug_res |-> $past(dbg_cycle) && $past(DEBUG_ACTIVE) &&
			!MAP_SEL.flash && !MAP_SEL.ram && !MAP_SEL.regs;
	endproperty
	a_debug_cycles: assert property (p_debug_cycles)
		else $error("debug resources selected outside debug cycles");

	property p_fixed_top;
		@(posedge CLOCK) disable iff (RESET)
		CPU_REQ.valid && !CPU_REQ.direct && CPU_REQ.addr[15:14] == REG_FIXED
			|=> GLOBAL_ADDR[17:14] == NIB_FIXED;
	endproperty
	a_fixed_top: assert property (p_fixed_top)
		else $error("upper block not mapped to fixed page");

	property p_illegal;
		@(posedge CLOCK) disable iff (RESET)
		ILLEGAL_RESET |-> MAP_SEL.unimpl && !$past(dbg_cycle) && !$past(CPU_REQ.firmware);
	endproperty
	a_illegal: assert property (p_illegal)
		else $error("illegal access reset without unimplemented cpu access");

endmodule : memory_map_control

// [rtl/mmc_pkg.sv]
package mmc_pkg;

	// ****************************************
	// register indices (byte address = 4 * index)
	// ****************************************
	localparam logic [7:0]  IDX_PAGE      = 8'h30;
	localparam logic [7:0]  IDX_DIRECT    = 8'h31;
	localparam logic [7:0]  IDX_MODE      = 8'h32;
	localparam logic [7:0]  IDX_CTRL      = 8'h33;
	localparam logic [7:0]  IDX_STATUS    = 8'h34;

	// ****************************************
	// fields and reset values
	// ****************************************
	localparam logic [3:0]  PAGE_RESET    = 4'hE;
	localparam logic [3:0]  PAGE_UPPER    = 4'hF;
	localparam logic [7:0]  DIRECT_RESET  = 8'h00;
	localparam int          MODE_BIT      = 7;
	localparam int          INFO_BIT      = 0;
	localparam logic        MODE_SPECIAL  = 1'b0;
	localparam logic        MODE_NORMAL   = 1'b1;

	// ****************************************
	// map constants
	// ****************************************
	localparam logic [1:0]  REG_LOW       = 2'b00;
	localparam logic [1:0]  REG_MID       = 2'b01;
	localparam logic [1:0]  REG_WINDOW    = 2'b10;
	localparam logic [1:0]  REG_FIXED     = 2'b11;
	localparam logic [3:0]  NIB_LOW       = 4'h0;
	localparam logic [3:0]  NIB_MID       = 4'hD;
	localparam logic [3:0]  NIB_FIXED     = 4'hF;
	localparam logic [7:0]  DBG_HI_TOP    = 8'hFF;
	localparam logic [7:0]  DBG_HI_ALIAS  = 8'hBF;
	localparam logic [7:0]  DBG_PAGE      = 8'hFF;
	localparam logic [18:0] REG_TOP       = 19'h0_03FF;
	localparam logic [18:0] INFO_LO       = 19'h0_0400;
	localparam logic [18:0] INFO_HI       = 19'h0_047F;
	localparam logic [18:0] RAM_LO        = 19'h0_0800;
	localparam logic [18:0] GLOBAL_END    = 19'h4_0000;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic        valid;
		logic        direct;
		logic        firmware;
		logic        dbg_rd;
		logic        dbg_wr;
		logic [15:0] addr;
	} cpu_req_t;

	typedef struct packed {
		logic regs;
		logic info_row;
		logic ram;
		logic flash;
		logic debug_res;
		logic unimpl;
	} map_sel_t;

	typedef struct packed {
		logic [3:0]  page;
		logic [7:0]  direct;
		logic        mode;
		logic        captured;
		logic        direct_written;
		logic        mode_lock;
		logic        info_vis;
		logic [31:0] prdata;
		logic [17:0] gaddr;
		map_sel_t    sel;
		logic        illegal;
	} mmc_state_t;

endpackage : mmc_pkg

// [rtl/mode_guard.sv]
`timescale 1ns/1ps
module mode_guard (
	// current state
	input  wire logic cur_mode,
	input  wire logic cur_lock,
	input  wire logic secured,
	// write request
	input  wire logic wr_val,
	// decision
	output logic      next_mode,
	output logic      next_lock
);
	import mmc_pkg::*;

	logic allowed;

	always_comb begin
		allowed   = (cur_mode == MODE_SPECIAL) && (wr_val == MODE_NORMAL);
		next_mode = cur_mode;
		next_lock = cur_lock;
		if (wr_val == cur_mode) begin
			next_mode = cur_mode;
		end else if (secured || cur_lock || !allowed) begin
			// refused: bit kept; outside special modes it also locks
			next_lock = cur_lock || (cur_mode != MODE_SPECIAL);
		end else begin
			next_mode = wr_val;
		end
	end

endmodule : mode_guard

// [rtl/addr_translate.sv]
`timescale 1ns/1ps
module addr_translate #(
	parameter int RAM_SIZE   = 2048,
	parameter int FLASH_SIZE = 32768
) (
	// request and map state
	input  mmc_pkg::cpu_req_t req,
	input  wire logic [3:0]   page,
	input  wire logic [7:0]   direct,
	input  wire logic         info_vis,
	input  wire logic         dbg_active,
	// result
	output logic [17:0]       gaddr,
	output mmc_pkg::map_sel_t sel
);
	import mmc_pkg::*;

	localparam logic [18:0] RAM_END   = RAM_LO + 19'(RAM_SIZE);
	localparam logic [18:0] FLASH_LOW = GLOBAL_END - 19'(FLASH_SIZE);

	logic [15:0] local_addr;
	logic [3:0]  nib;
	logic [18:0] g;
	logic        dbg_hit;

	always_comb begin
		// direct page supplies the high byte in either scheme
		local_addr = req.direct ? {direct, req.addr[7:0]} : req.addr;
		unique case (local_addr[15:14])
			REG_LOW:    nib = NIB_LOW;
			REG_MID:    nib = NIB_MID;
			REG_WINDOW: nib = page;
			REG_FIXED:  nib = NIB_FIXED;
		endcase
		gaddr   = {nib, local_addr[13:0]};
		g       = {1'b0, gaddr};
		dbg_hit = dbg_active && ((local_addr[15:8] == DBG_HI_TOP) ||
			((local_addr[15:8] == DBG_HI_ALIAS) && ({PAGE_UPPER, page} == DBG_PAGE)));
		sel           = '0;
		sel.debug_res = dbg_hit && (req.dbg_rd || req.dbg_wr);
		if (!dbg_hit) begin
			sel.regs     = g <= REG_TOP;
			sel.info_row = info_vis && (g >= INFO_LO) && (g <= INFO_HI);
			sel.ram      = (g >= RAM_LO) && (g < RAM_END);
			sel.flash    = g >= FLASH_LOW;
		end
		sel.unimpl = !(sel.regs || sel.info_row || sel.ram || sel.flash || dbg_hit);
	end

endmodule : addr_translate

// [tb/cpu_master_model.sv]
`timescale 1ns/1ps
// ****************************************
// cpu and debug master model
// ****************************************
module cpu_master_model (
	// clock
	input  wire logic         clock,
	// commands from bench
	input  mmc_pkg::cpu_req_t req_in,
	input  wire logic         page_go,
	input  wire logic [7:0]   page_val,
	// towards the block
	output mmc_pkg::cpu_req_t cpu_req,
	output logic              page_wr,
	output logic      [7:0]   page_wdata
);
	import mmc_pkg::*;

	initial begin
		cpu_req    = '0;
		page_wr    = 1'b0;
		page_wdata = 8'h00;
	end

	// idle address toggles so a stale value never passes for a live one
	always @(posedge clock) begin
		cpu_req    <= req_in.valid ? req_in : {1'b0, cpu_req[19:16], ~cpu_req[15:0]};
		page_wr    <= page_go;
		page_wdata <= page_go ? page_val : ~page_wdata;
	end
endmodule : cpu_master_model

// [tb/tb_memory_map_control.sv]
`timescale 1ns/1ps
module tb_memory_map_control;
	import mmc_pkg::*;
	logic        CLOCK, RESET, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, PAGE_WR;
	logic        MODE_PIN, SECURED, DEBUG_ACTIVE, ILLEGAL_RESET, OP_MODE_SPECIAL;
	logic        DEBUG_CONTROL, EXT_BUS_EN, page_go, v1, vis;
	logic [11:0] PADDR;
	logic [31:0] PWDATA, PRDATA;
	logic [7:0]  PAGE_WDATA, PAGE_RDATA, page_val, base;
	logic [17:0] GLOBAL_ADDR;
	logic [3:0]  page;
	cpu_req_t    CPU_REQ, req_in;
	map_sel_t    MAP_SEL;
	logic [32:0] qrd[$];
	logic [24:0] qmap[$];
	int          n_mismatch, total_checks, seed, i;

	memory_map_control u_dut (.CLOCK(CLOCK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .MODE_PIN(MODE_PIN), .SECURED(SECURED), .DEBUG_ACTIVE(DEBUG_ACTIVE),
		.PAGE_WR(PAGE_WR), .PAGE_WDATA(PAGE_WDATA), .PAGE_RDATA(PAGE_RDATA), .CPU_REQ(CPU_REQ),
		.GLOBAL_ADDR(GLOBAL_ADDR), .MAP_SEL(MAP_SEL), .ILLEGAL_RESET(ILLEGAL_RESET),
		.OP_MODE_SPECIAL(OP_MODE_SPECIAL), .DEBUG_CONTROL(DEBUG_CONTROL), .EXT_BUS_EN(EXT_BUS_EN));
	cpu_master_model u_cpu (.clock(CLOCK), .req_in(req_in), .page_go(page_go),
		.page_val(page_val), .cpu_req(CPU_REQ), .page_wr(PAGE_WR), .page_wdata(PAGE_WDATA));

	initial begin
		CLOCK = 1'b0;
		forever #5 CLOCK = ~CLOCK;
	end

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : tally_and_finish

	// expected {global, select, illegal} from the tracked map state
	function automatic logic [24:0] ref_map(input cpu_req_t r);
		logic [15:0] l;
		logic [17:0] g;
		logic        hit;
		logic        dc;
		map_sel_t    s;
		l = r.direct ? {base, r.addr[7:0]} : r.addr;
		case (l[15:14])
			2'b00: g = {4'h0, l[13:0]};
			2'b01: g = {4'hD, l[13:0]};
			2'b10: g = {page, l[13:0]};
			default: g = {4'hF, l[13:0]};
		endcase
		hit = DEBUG_ACTIVE && (l[15:8] == 8'hFF || (l[15:8] == 8'hBF && page == 4'hF));
		dc = r.dbg_rd | r.dbg_wr;
		s.regs      = !hit && g <= 18'h0_03FF;
		s.info_row  = !hit && vis && g >= 18'h0_0400 && g <= 18'h0_047F;
		s.ram       = !hit && g >= 18'h0_0800 && g <= 18'h0_0FFF;
		s.flash     = !hit && g >= 18'h3_8000;
		s.debug_res = hit && dc;
		s.unimpl    = !hit && !(s.regs | s.info_row | s.ram | s.flash);
		return {g, s, s.unimpl && !r.firmware && !dc};
	endfunction : ref_map

	task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d,
		input logic [32:0] e);
		int n;
		@(posedge CLOCK);
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= w;
		PADDR <= {2'b00, idx, 2'b00};
		PWDATA <= d;
		if (!w)
			qrd.push_back(e);
		@(posedge CLOCK);
		PENABLE <= 1'b1;
		n = 0;
		do begin
			@(posedge CLOCK);
			n++;
		end while (PREADY !== 1'b1 && n < 20);
		if (PREADY !== 1'b1) begin
			n_mismatch++;
			tally_and_finish;
		end
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		apb(1'b1, idx, {24'h00_0000, d}, 33'h0_0000_0000);
	endtask : wr

	task automatic rd(input logic [7:0] idx, input logic [7:0] e);
		apb(1'b0, idx, 32'h0000_0000, {25'h000_0000, e});
	endtask : rd

	// f = {direct, firmware, debug read, debug write}
	task automatic cpu(input logic [15:0] a, input logic [3:0] f);
		@(posedge CLOCK);
		req_in <= {1'b1, f, a};
		qmap.push_back(ref_map({1'b1, f, a}));
		@(posedge CLOCK);
		req_in.valid <= 1'b0;
	endtask : cpu

	task automatic far_page(input logic [7:0] v);
		@(posedge CLOCK);
		page_go <= 1'b1;
		page_val <= v;
		@(posedge CLOCK);
		page_go <= 1'b0;
		repeat (2) @(posedge CLOCK);
		page = v[3:0];
		chk("page_rdata", {4'hF, v[3:0]}, PAGE_RDATA);
	endtask : far_page

	task automatic do_reset(input logic mp, input logic sec);
		RESET <= 1'b1;
		MODE_PIN <= mp;
		SECURED <= sec;
		repeat (8) @(posedge CLOCK);
		chk("mode in reset", !mp, OP_MODE_SPECIAL);
		RESET <= 1'b0;
		page = 4'hE;
		base = 8'h00;
		vis = 1'b0;
	endtask : do_reset

	// ****************************************
	// result monitor
	// ****************************************
	always @(posedge CLOCK) begin
		if (!RESET && PSEL && PENABLE && !PWRITE && PREADY) begin
			if (qrd.size() == 0)
				chk("read note", 1, 0);
			else
				chk("apb read", qrd.pop_front(), {PSLVERR, PRDATA});
		end
		if (!RESET && v1) begin
			if (qmap.size() == 0)
				chk("map note", 1, 0);
			else
				chk("cpu map", qmap.pop_front(), {GLOBAL_ADDR, MAP_SEL, ILLEGAL_RESET});
		end else if (!RESET)
			chk("idle map_sel", 0, MAP_SEL);
		v1 <= CPU_REQ.valid;
	end

	initial begin
		repeat (20000) @(posedge CLOCK);
		n_mismatch++;
		tally_and_finish;
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		seed = 14;
		n_mismatch = 0;
		total_checks = 0;
		RESET = 1'b1;
		{PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
		{MODE_PIN, SECURED, DEBUG_ACTIVE, page_go, page_val, v1} = '0;
		req_in = '0;
		do_reset(1'b1, 1'b0);
		rd(IDX_PAGE, 8'hFE);
		// pin may move only once the capture edge has passed
		MODE_PIN <= 1'b0;
		rd(IDX_MODE, 8'h80);
		chk("special", 0, OP_MODE_SPECIAL);
		chk("ext bus", 0, EXT_BUS_EN);
		wr(IDX_MODE, 8'h00);
		rd(IDX_MODE, 8'h80);
		rd(IDX_STATUS, 8'h09);
		wr(IDX_DIRECT, 8'h80);
		wr(IDX_DIRECT, 8'h12);
		rd(IDX_DIRECT, 8'h80);
		base = 8'h80;
		cpu(16'h0034, 4'b1000);
		apb(1'b0, 8'h35, 32'h0000_0000, 33'h1_0000_0000);
		// special mode: base rewritable, lock gone after reset
		do_reset(1'b0, 1'b0);
		chk("debug control", 1, DEBUG_CONTROL);
		wr(IDX_DIRECT, 8'h11);
		wr(IDX_DIRECT, 8'h22);
		rd(IDX_DIRECT, 8'h22);
		base = 8'h22;
		cpu(16'h0040, 4'b1000);
		wr(IDX_MODE, 8'h80);
		rd(IDX_MODE, 8'h80);
		wr(IDX_MODE, 8'h00);
		rd(IDX_STATUS, 8'h0B);
		do_reset(1'b0, 1'b1);
		wr(IDX_MODE, 8'h80);
		rd(IDX_MODE, 8'h00);
		wr(IDX_CTRL, 8'h01);
		vis = 1'b1;
		rd(IDX_CTRL, 8'h01);
		cpu(16'h0400, 4'b0000);
		cpu(16'h047F, 4'b0000);
		cpu(16'h0480, 4'b0000);
		wr(IDX_CTRL, 8'h00);
		vis = 1'b0;
		cpu(16'h0400, 4'b0000);
		cpu(16'h0400, 4'b0100);
		cpu(16'h0400, 4'b0010);
		DEBUG_ACTIVE <= 1'b1;
		cpu(16'hFF10, 4'b0010);
		cpu(16'hFF10, 4'b0000);
		cpu(16'hBF20, 4'b0001);
		far_page(8'hFF);
		cpu(16'hBF20, 4'b0001);
		wr(IDX_PAGE, 8'hF3);
		page = 4'h3;
		rd(IDX_PAGE, 8'hF3);
		cpu(16'hBF20, 4'b0001);
		repeat (2) @(posedge CLOCK);
		DEBUG_ACTIVE <= 1'b0;
		repeat (2) @(posedge CLOCK);
		for (i = 0; i < 40; i++) begin
			far_page($random(seed));
			cpu($random(seed), $random(seed));
		end
		repeat (4) @(posedge CLOCK);
		chk("pending notes", 0, qrd.size() + qmap.size());
		tally_and_finish;
	end
endmodule : tb_memory_map_control
